// ---- hw/srr_defines.svh ----
/*
  Offsets, widths and preset values for the status reporting registers.
  Assumes inclusion by bare name from any design or bench file.
*/
`ifndef SRR_DEFINES_SVH
`define SRR_DEFINES_SVH
`define SRR_W 15
`define SRR_MAX 15'h7fff
`define SRR_RISE_PRESET 15'h7fff
`define SRR_FALL_PRESET 15'h0000
`define SRR_MASK_PRESET 15'h0000
`define SRR_RST_VAL 15'h0000
`define SRR_A_OPER_LIVE 4'h0
`define SRR_A_OPER_MASK 4'h1
`define SRR_A_OPER_EVT 4'h2
`define SRR_A_OPER_FALL 4'h3
`define SRR_A_OPER_RISE 4'h4
`define SRR_A_QUES_LIVE 4'h5
`define SRR_A_QUES_MASK 4'h6
`define SRR_A_QUES_EVT 4'h7
`define SRR_A_QUES_FALL 4'h8
`define SRR_A_QUES_RISE 4'h9
`endif

// ---- hw/srr_pkg.sv ----
/*
  Types for the status reporting registers.
  Assumes srr_defines.svh is compiled alongside.
*/
package srr_pkg;
  typedef logic [14:0] srr_word_t;
  typedef enum logic [1:0] {
    SRR_GRP_CTL_IDLE = 2'b00,
    SRR_GRP_CTL_READ = 2'b01
  } srr_access_t;
endpackage

// ---- hw/srr_group.sv ----
/*
  One status group: live state, transition filters, sticky events, mask.
  Assumes condition input synchronous to clk; read/write strobes one cycle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "srr_defines.svh"
module srr_group (
  input wire logic clk,
  input wire logic rstn,
  input wire srr_pkg::srr_word_t cond,
  input wire logic preset,
  input wire logic wr_mask,
  input wire logic wr_rise,
  input wire logic wr_fall,
  input wire srr_pkg::srr_word_t wdata,
  input wire logic rd_evt,
  output srr_pkg::srr_word_t live,
  output srr_pkg::srr_word_t events,
  output srr_pkg::srr_word_t mask,
  output srr_pkg::srr_word_t rise,
  output srr_pkg::srr_word_t fall,
  output logic summary
);
  srr_pkg::srr_word_t cond_prev_r, evt_r, mask_r, rise_r, fall_r;
  srr_pkg::srr_word_t hit, evt_nxt;

  assign hit = (cond & ~cond_prev_r & rise_r) | (~cond & cond_prev_r & fall_r);
  // clear on read, new edge wins
  assign evt_nxt = (rd_evt ? `SRR_RST_VAL : evt_r) | hit;
  assign summary = |(evt_r & mask_r);
  assign live = cond;
  assign events = evt_r;
  assign mask = mask_r;
  assign rise = rise_r;
  assign fall = fall_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cond_prev_r <= `SRR_RST_VAL;
      evt_r <= `SRR_RST_VAL;
      mask_r <= `SRR_MASK_PRESET;
      rise_r <= `SRR_RISE_PRESET;
      fall_r <= `SRR_FALL_PRESET;
    end else begin
      cond_prev_r <= cond;
      evt_r <= evt_nxt;
      if (preset) begin
        mask_r <= `SRR_MASK_PRESET;
        rise_r <= `SRR_RISE_PRESET;
        fall_r <= `SRR_FALL_PRESET;
      end else begin
        if (wr_mask) mask_r <= wdata;
        if (wr_rise) rise_r <= wdata;
        if (wr_fall) fall_r <= wdata;
      end
    end
  end

  property p_edge_survives;
    @(posedge clk) disable iff (!rstn)
      (hit != 15'h0000) |=> ((evt_r & $past(hit)) == $past(hit));
  endproperty
  a_edge_survives: assert property (p_edge_survives)
    else $error("edge lost");
  property p_read_clears;
    @(posedge clk) disable iff (!rstn)
      (rd_evt && hit == 15'h0000) |=> (evt_r == `SRR_RST_VAL);
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("read did not clear");
  property p_rise;
    @(posedge clk) disable iff (!rstn)
      (cond[0] && !cond_prev_r[0] && rise_r[0]) |=> evt_r[0];
  endproperty
  a_rise: assert property (p_rise)
    else $error("rise missed");
  property p_fall;
    @(posedge clk) disable iff (!rstn)
      (!cond[0] && cond_prev_r[0] && fall_r[0]) |=> evt_r[0];
  endproperty
  a_fall: assert property (p_fall)
    else $error("fall missed");
  property p_preset;
    @(posedge clk) disable iff (!rstn)
      preset |=> (rise_r == `SRR_RISE_PRESET &&
        fall_r == `SRR_FALL_PRESET && mask_r == `SRR_MASK_PRESET);
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset wrong");
  property p_write;
    @(posedge clk) disable iff (!rstn)
      (wr_mask && !preset) |=> (mask_r == $past(wdata));
  endproperty
  a_write: assert property (p_write)
    else $error("mask write lost");
  property p_sum;
    @(posedge clk) disable iff (!rstn)
      ((evt_r & mask_r) == 15'h0000) |-> !summary;
  endproperty
  a_sum: assert property (p_sum)
    else $error("summary wrong");
  property p_sticky;
    @(posedge clk) disable iff (!rstn)
      (!rd_evt && evt_r[0]) |=> evt_r[0];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("event not sticky");
  c_rise: cover property (@(posedge clk) disable iff (!rstn) hit != 15'h0000);
  c_rdhit: cover property (@(posedge clk) disable iff (!rstn)
    rd_evt && hit != 15'h0000);
  c_sum: cover property (@(posedge clk) disable iff (!rstn) summary);
endmodule
`default_nettype wire

// ---- hw/srr_top.sv ----
/*
  Status reporting block: operation and questionable groups behind a simple
  command port. Assumes one-cycle rd/wr strobes from the command decoder.
*/
`timescale 1ns/10ps
`default_nettype none
`include "srr_defines.svh"
module srr_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [14:0] oper_cond,
  input wire logic [14:0] ques_cond,
  input wire logic status_preset,
  input wire logic instr_reset,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [3:0] cmd_addr,
  input wire logic [14:0] cmd_wdata,
  output logic [14:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic oper_summary,
  output logic ques_summary
);
  srr_pkg::srr_word_t o_live, o_evt, o_mask, o_rise, o_fall;
  srr_pkg::srr_word_t q_live, q_evt, q_mask, q_rise, q_fall;
  srr_pkg::srr_word_t rdata_nxt;
  logic [14:0] rdata_r;
  logic rvalid_r;
  wire logic o_sum, q_sum;
  wire logic rd_oevt = cmd_rd && cmd_addr == `SRR_A_OPER_EVT;
  wire logic rd_qevt = cmd_rd && cmd_addr == `SRR_A_QUES_EVT;
  wire logic wr_om = cmd_wr && cmd_addr == `SRR_A_OPER_MASK;
  wire logic wr_or = cmd_wr && cmd_addr == `SRR_A_OPER_RISE;
  wire logic wr_of = cmd_wr && cmd_addr == `SRR_A_OPER_FALL;
  wire logic wr_qm = cmd_wr && cmd_addr == `SRR_A_QUES_MASK;
  wire logic wr_qr = cmd_wr && cmd_addr == `SRR_A_QUES_RISE;
  wire logic wr_qf = cmd_wr && cmd_addr == `SRR_A_QUES_FALL;
  // instrument reset is not wired to any register
  wire logic unused_reset = instr_reset;

  srr_group u_oper (
    .clk(clk), .rstn(rstn), .cond(oper_cond), .preset(status_preset),
    .wr_mask(wr_om), .wr_rise(wr_or), .wr_fall(wr_of), .wdata(cmd_wdata),
    .rd_evt(rd_oevt), .live(o_live), .events(o_evt), .mask(o_mask),
    .rise(o_rise), .fall(o_fall), .summary(o_sum)
  );
  srr_group u_ques (
    .clk(clk), .rstn(rstn), .cond(ques_cond), .preset(status_preset),
    .wr_mask(wr_qm), .wr_rise(wr_qr), .wr_fall(wr_qf), .wdata(cmd_wdata),
    .rd_evt(rd_qevt), .live(q_live), .events(q_evt), .mask(q_mask),
    .rise(q_rise), .fall(q_fall), .summary(q_sum)
  );

  always_comb begin
    unique case (cmd_addr)
      `SRR_A_OPER_LIVE: rdata_nxt = o_live;
      `SRR_A_OPER_MASK: rdata_nxt = o_mask;
      `SRR_A_OPER_EVT: rdata_nxt = o_evt;
      `SRR_A_OPER_FALL: rdata_nxt = o_fall;
      `SRR_A_OPER_RISE: rdata_nxt = o_rise;
      `SRR_A_QUES_LIVE: rdata_nxt = q_live;
      `SRR_A_QUES_MASK: rdata_nxt = q_mask;
      `SRR_A_QUES_EVT: rdata_nxt = q_evt;
      `SRR_A_QUES_FALL: rdata_nxt = q_fall;
      `SRR_A_QUES_RISE: rdata_nxt = q_rise;
      default: rdata_nxt = `SRR_RST_VAL;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= `SRR_RST_VAL;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= cmd_rd;
      if (cmd_rd) rdata_r <= rdata_nxt;
    end
  end

  assign cmd_rdata = rdata_r;
  assign cmd_rvalid = rvalid_r;
  assign oper_summary = o_sum;
  assign ques_summary = q_sum;

  property p_evt_read;
    @(posedge clk) disable iff (!rstn)
      rd_oevt |=> (cmd_rdata == $past(o_evt));
  endproperty
  a_evt_read: assert property (p_evt_read)
    else $error("event read wrong");
  // operation read clears when no edge
  property p_o_clear;
    @(posedge clk) disable iff (!rstn)
      (rd_oevt && $stable(oper_cond)) |=> (o_evt == `SRR_RST_VAL);
  endproperty
  a_o_clear: assert property (p_o_clear)
    else $error("oper clear");
  property p_q_evt_read;
    @(posedge clk) disable iff (!rstn)
      rd_qevt |=> (cmd_rdata == $past(q_evt));
  endproperty
  a_q_evt_read: assert property (p_q_evt_read)
    else $error("ques event read wrong");
  property p_q_clear;
    @(posedge clk) disable iff (!rstn)
      (rd_qevt && $stable(ques_cond)) |=> (q_evt == `SRR_RST_VAL);
  endproperty
  a_q_clear: assert property (p_q_clear)
    else $error("ques clear");
  property p_live;
    @(posedge clk) disable iff (!rstn)
      (cmd_rd && cmd_addr == `SRR_A_OPER_LIVE) |=>
        (cmd_rdata == $past(oper_cond));
  endproperty
  a_live: assert property (p_live)
    else $error("live read wrong");
  property p_live_keep;
    @(posedge clk) disable iff (!rstn)
      (cmd_rd && cmd_addr == `SRR_A_OPER_LIVE && $stable(oper_cond)) |=>
        $stable(o_evt);
  endproperty
  a_live_keep: assert property (p_live_keep)
    else $error("live read side effect");
  property p_q_live;
    @(posedge clk) disable iff (!rstn)
      (cmd_rd && cmd_addr == `SRR_A_QUES_LIVE) |=>
        (cmd_rdata == $past(ques_cond));
  endproperty
  a_q_live: assert property (p_q_live)
    else $error("ques live read wrong");
  property p_q_live_keep;
    @(posedge clk) disable iff (!rstn)
      (cmd_rd && cmd_addr == `SRR_A_QUES_LIVE && $stable(ques_cond)) |=>
        $stable(q_evt);
  endproperty
  a_q_live_keep: assert property (p_q_live_keep)
    else $error("ques live read side effect");
  property p_osum;
    @(posedge clk) disable iff (!rstn)
      oper_summary == (|(o_evt & o_mask));
  endproperty
  a_osum: assert property (p_osum)
    else $error("oper summary");
  property p_qsum;
    @(posedge clk) disable iff (!rstn)
      ques_summary == (|(q_evt & q_mask));
  endproperty
  a_qsum: assert property (p_qsum)
    else $error("ques summary");
  property p_keep;
    @(posedge clk) disable iff (!rstn)
      (instr_reset && !cmd_wr && !status_preset) |=>
        ($stable(o_mask) && $stable(o_rise) && $stable(o_fall));
  endproperty
  a_keep: assert property (p_keep)
    else $error("reset changed oper parts");
  property p_q_keep;
    @(posedge clk) disable iff (!rstn)
      (instr_reset && !cmd_wr && !status_preset) |=>
        ($stable(q_mask) && $stable(q_rise) && $stable(q_fall));
  endproperty
  a_q_keep: assert property (p_q_keep)
    else $error("reset changed ques parts");
  property p_evt_wr;
    @(posedge clk) disable iff (!rstn)
      (cmd_wr && cmd_addr == `SRR_A_OPER_EVT && !cmd_rd &&
        $stable(oper_cond)) |=> $stable(o_evt);
  endproperty
  a_evt_wr: assert property (p_evt_wr)
    else $error("event write landed");
  property p_unmapped;
    @(posedge clk) disable iff (!rstn)
      (cmd_rd && cmd_addr > `SRR_A_QUES_RISE) |=>
        (cmd_rdata == `SRR_RST_VAL);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_q_wr;
    @(posedge clk) disable iff (!rstn)
      (cmd_wr && cmd_addr == `SRR_A_QUES_RISE && !status_preset) |=>
        (q_rise == $past(cmd_wdata));
  endproperty
  a_q_wr: assert property (p_q_wr)
    else $error("ques rise write lost");
  property p_preset_mask;
    @(posedge clk) disable iff (!rstn)
      status_preset |=>
        (o_mask == `SRR_MASK_PRESET && q_mask == `SRR_MASK_PRESET);
  endproperty
  a_preset_mask: assert property (p_preset_mask)
    else $error("preset mask wrong");
  property p_preset_fall;
    @(posedge clk) disable iff (!rstn)
      status_preset |=>
        (o_fall == `SRR_FALL_PRESET && q_fall == `SRR_FALL_PRESET);
  endproperty
  a_preset_fall: assert property (p_preset_fall)
    else $error("preset fall wrong");
  property p_rdata_hold;
    @(posedge clk) disable iff (!rstn)
      !cmd_rd |=> $stable(cmd_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved");
  property p_rvalid;
    @(posedge clk) disable iff (!rstn)
      1'b1 |=> (cmd_rvalid == $past(cmd_rd));
  endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read valid wrong");
  c_oread: cover property (@(posedge clk) disable iff (!rstn)
    rd_oevt && o_evt != 15'h0000);
  c_qsum: cover property (@(posedge clk) disable iff (!rstn) ques_summary);
endmodule
`default_nettype wire

// ---- dv/srr_host.sv ----
/*
  Command host model: one-cycle reads and writes, expected words noted.
  Assumes each task is entered just after a falling clk edge.
*/
`timescale 1ns/10ps
`default_nettype none
module srr_host (
  input wire logic clk,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [3:0] cmd_addr,
  output logic [14:0] cmd_wdata
);
  logic [18:0] exp_q[$];
  initial begin
    cmd_wr = 1'h0;
    cmd_rd = 1'h0;
    cmd_addr = 4'h0;
    cmd_wdata = 15'h0000;
  end
  task automatic wr(input logic [3:0] a, input logic [14:0] d);
    cmd_wr = 1'h1;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge clk);
    cmd_wr = 1'h0;
    cmd_addr = ~a;
    cmd_wdata = ~d;
    @(negedge clk);
  endtask
  // Note goes in before the request so the watcher never finds it empty
  task automatic rd(input logic [3:0] a, input logic [14:0] e);
    exp_q.push_back({a, e});
    cmd_rd = 1'h1;
    cmd_addr = a;
    @(negedge clk);
    cmd_rd = 1'h0;
    cmd_addr = ~a;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ---- dv/srr_top_tb.sv ----
/*
  Self-checking bench for the status reporting block.
  Assumes srr_host drives the command port; bench drives the rest.
*/
`timescale 1ns/10ps
`default_nettype none
module srr_top_tb;
  logic clk, rstn, status_preset, instr_reset;
  logic cmd_wr, cmd_rd, cmd_rvalid, oper_summary, ques_summary;
  logic [14:0] oper_cond, ques_cond, cmd_wdata, cmd_rdata, r, c, m, f;
  logic [3:0] cmd_addr, b;
  logic [18:0] note;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  srr_top u_srr_top (.clk(clk), .rstn(rstn), .oper_cond(oper_cond),
    .ques_cond(ques_cond), .status_preset(status_preset),
    .instr_reset(instr_reset), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid), .oper_summary(oper_summary),
    .ques_summary(ques_summary));
  srr_host u_srr_host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic check_word(input logic [3:0] a, input logic [14:0] e,
                            input logic [14:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED reg %0h expected %h seen %h", a, e, g);
    end
  endtask
  task automatic check_bit(input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED summary expected %b seen %b", e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic set_cond(input int g, input logic [14:0] v);
    if (g == 1) ques_cond = v;
    else oper_cond = v;
  endtask
  function automatic logic summ(input int g);
    return (g == 1) ? ques_summary : oper_summary;
  endfunction
  always @(negedge clk) begin
    if (cmd_rvalid === 1'h1) begin
      if (u_srr_host.exp_q.size() > 0) begin
        note = u_srr_host.exp_q.pop_front();
        check_word(note[18:15], note[14:0], cmd_rdata);
      end else begin
        error_cnt++;
        $display("CHECK FAILED rvalid expected 0 seen 1");
      end
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    rstn = 1'h0;
    status_preset = 1'h0;
    instr_reset = 1'h0;
    oper_cond = 15'h0000;
    ques_cond = 15'h0000;
    void'($urandom(45567));
    repeat (12) @(negedge clk);
    rstn = 1'h1;
    @(negedge clk);
    for (int i = 0; i < 16; i++) begin
      u_srr_host.rd(4'(i), (i == 4 || i == 9) ? 15'h7fff : 15'h0000);
    end
    $display("test reset values done");
    for (int g = 0; g < 2; g++) begin
      b = 4'(g * 5);
      r = 15'($urandom);
      c = 15'($urandom);
      m = 15'($urandom);
      f = 15'($urandom);
      u_srr_host.wr(b + 4'h4, r);
      u_srr_host.wr(b, 15'h1234);
      u_srr_host.wr(b + 4'h2, 15'h7fff);
      set_cond(g, c);
      u_srr_host.wr(b + 4'h1, ~(c & r));
      check_bit(1'h0, summ(g));
      u_srr_host.wr(b + 4'h1, m);
      check_bit(|(c & r & m), summ(g));
      u_srr_host.rd(b, c);
      u_srr_host.rd(b, c);
      u_srr_host.rd(b + 4'h1, m);
      u_srr_host.rd(b + 4'h2, c & r);
      u_srr_host.rd(b + 4'h2, 15'h0000);
      check_bit(1'h0, summ(g));
      u_srr_host.wr(b + 4'h3, f);
      u_srr_host.wr(b + 4'h4, 15'h0000);
      set_cond(g, 15'h0000);
      u_srr_host.rd(b + 4'h3, f);
      u_srr_host.rd(b + 4'h2, c & f);
      u_srr_host.wr(b + 4'h4, 15'h7fff);
      // edge lands with the clearing read
      set_cond(g, 15'h0001);
      u_srr_host.rd(b + 4'h2, 15'h0000);
      u_srr_host.rd(b + 4'h2, 15'h0001);
      instr_reset = 1'h1;
      @(negedge clk);
      instr_reset = 1'h0;
      u_srr_host.rd(b + 4'h1, m);
      u_srr_host.rd(b + 4'h3, f);
      status_preset = 1'h1;
      @(negedge clk);
      status_preset = 1'h0;
      u_srr_host.rd(b + 4'h4, 15'h7fff);
      u_srr_host.rd(b + 4'h3, 15'h0000);
      u_srr_host.rd(b + 4'h1, 15'h0000);
      set_cond(g, 15'h0000);
      $display("test group %0d done", g);
    end
    repeat (3) @(negedge clk);
    if (u_srr_host.exp_q.size() != 0) begin
      error_cnt++;
      $display("CHECK FAILED pending reads expected 0 seen %0d",
               u_srr_host.exp_q.size());
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
